// file: dv/decode_sva.sv
`timescale 1ns/10ps
module decode_sva (input wire logic ref_clk, rst, power_on_clear,
  input wire logic cpu_wait_ack, bus_ready_line, cpu_data_in_oe, chip_wdata_oe,
  input wire logic [5:0] board_address,
  input wire serial_bus_decode_pkg::host_cycle_s host,
  input wire serial_bus_decode_pkg::chip_ctrl_s chip);
  // board match, input cycle, any selected cycle
  wire sel = host.addr[7:2] == board_address;
  wire rd = sel && host.in_cycle;
  wire cyc = sel && (host.in_cycle || host.out_cycle);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_cs_sel: assert property (chip.chip_select_low_n == !cyc)
    else $error("cs");
  a_port_pick: assert property (cyc |->
    chip.chip_select_high == {host.addr[1], !host.addr[1]}) else $error("port");
  a_enable_src: assert property (cyc |->
    chip.enable == (!host.wr_strobe_n || host.din_strobe)) else $error("en");
  a_write_dir: assert property (sel && host.out_cycle |->
    !chip.read_not_write && chip_wdata_oe) else $error("wr");
  a_wait_set: assert property ($rose(rd) && !cpu_wait_ack &&
    !power_on_clear |=> !bus_ready_line) else $error("wait");
  a_rdy_up: assert property (cpu_wait_ack || power_on_clear |=>
    bus_ready_line) else $error("ack");
  a_no_wait: assert property (!rd && bus_ready_line |=>
    bus_ready_line) else $error("out");
  a_idle_off: assert property (!cyc |->
    !cpu_data_in_oe && !chip_wdata_oe) else $error("idle");
  c_read: cover property (rd && host.din_strobe);
  c_write: cover property (sel && host.out_cycle);
  c_ack: cover property (cpu_wait_ack);
endmodule

// file: dv/host_wait_model.sv
`timescale 1ns/10ps
module host_wait_model (input wire logic ref_clk, rst, bus_ready_line,
  output logic cpu_wait_ack);
  // acknowledge a wait one cycle after it begins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) cpu_wait_ack <= 1'b0;
    else cpu_wait_ack <= !bus_ready_line;
  end
endmodule

// file: dv/serial_board_bus_decode_tb.sv
`timescale 1ns/10ps
module serial_board_bus_decode_tb;
  logic ref_clk = 1'b0, rst = 1'b1, power_on_clear = 1'b0, cpu_wait_ack;
  logic bus_ready_line, cpu_data_in_oe, chip_wdata_oe;
  logic [7:0] cpu_data_in, chip_wdata;
  serial_bus_decode_pkg::host_cycle_s host = '0;
  serial_bus_decode_pkg::chip_ctrl_s chip;
  int bad_count = 0, compares = 0;
  always #2.5 ref_clk = ~ref_clk; // 200 MHz
  serial_board_bus_decode u_dut (.*, .board_address(6'h05),
    .port0_rdata(8'h3c), .port1_rdata(8'ha5));
  host_wait_model u_host (.*);
  task automatic chk(input logic ok);
    compares++;
    if (ok !== 1'b1) bad_count++;
    if (ok !== 1'b1) $display("[ERR] %0t mismatch", $time);
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic read_scn();
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk) host <= {6'h05, i[1:0], 8'h00, 4'b1011};
      @(posedge ref_clk) #1;
      chk(!bus_ready_line && cpu_data_in_oe);
      chk(cpu_data_in === (i[1] ? 8'ha5 : 8'h3c));
      chk(chip.chip_select_high === {i[1], !i[1]});
      chk(chip.register_select === i[0]);
      repeat (9) if (bus_ready_line !== 1'b1) @(posedge ref_clk) #1;
      chk(bus_ready_line);
      if (bus_ready_line !== 1'b1) give_verdict();
      @(posedge ref_clk) host <= {16'h0000, 4'b0010};
    end
  endtask
  task automatic clear_scn(); // power-on clear drops a wait before the ack
    @(posedge ref_clk) host <= {6'h05, 2'h0, 8'h00, 4'b1011};
    @(posedge ref_clk) power_on_clear <= 1'b1;
    @(posedge ref_clk) #1;
    chk(bus_ready_line);
    @(posedge ref_clk) power_on_clear <= 1'b0;
    host <= {16'h0000, 4'b0010};
    repeat (3) @(posedge ref_clk) #1;
    chk(bus_ready_line && !cpu_data_in_oe);
  endtask
  task automatic write_scn();
    @(posedge ref_clk) host <= {8'h97, 8'h5a, 4'b0100};
    @(posedge ref_clk) #1;
    chk(chip.chip_select_low_n && !chip_wdata_oe);
    @(posedge ref_clk) host.addr <= 8'h17;
    repeat (3) @(posedge ref_clk) #1;
    chk(bus_ready_line && chip_wdata === 8'h5a);
    chk(!chip.read_not_write && chip.enable);
  endtask
  initial begin // reset, then the scenarios
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    read_scn();
    clear_scn();
    write_scn();
    give_verdict();
  end
endmodule
bind serial_board_bus_decode decode_sva u_sva (.*);

// file: hw/serial_board_bus_decode.sv
// Behaviour
// - board select when address bits seven..two match
// - chip select needs board select and an input or output cycle
// - bit one picks port, bit zero register
// - enable pulse from write or data-in strobe
// - output cycle: write low, drivers toward chip
// - input cycle: addressed register onto data-in
// - start of input cycle sets wait, ready line low
// - wait acknowledge clears wait, ready released
// - no wait state on output cycles
// - power-on clear empties wait flip-flop
`timescale 1ns/10ps
`include "serial_bus_decode_map.svh"

module serial_board_bus_decode (
  input  wire logic                               ref_clk,
  input  wire logic                               rst,
  input  wire logic                               power_on_clear,
  input  wire logic [5:0]                         board_address,
  input  wire serial_bus_decode_pkg::host_cycle_s host,
  input  wire logic                               cpu_wait_ack,
  input  wire logic [7:0]                         port0_rdata,
  input  wire logic [7:0]                         port1_rdata,
  output logic                                    bus_ready_line,
  output logic [7:0]                              cpu_data_in,
  output logic                                    cpu_data_in_oe,
  output logic [7:0]                              chip_wdata,
  output logic                                    chip_wdata_oe,
  output serial_bus_decode_pkg::chip_ctrl_s       chip
);

  serial_bus_decode_pkg::wait_state_e wait_ff;
  serial_bus_decode_pkg::wait_state_e nxt_wait;
  logic                               in_seen_ff;
  logic [7:0]                         din_ff;
  logic [7:0]                         nxt_din;

  wire logic       board_sel;
  wire logic       cycle_sel;
  wire logic       port_sel;
  wire logic       reg_sel;
  wire logic       strobe_on;
  wire logic       in_start;
  wire logic       rd_access;

  // address compare against the jumper base
  assign board_sel = (host.addr[`ADDR_BASE_MSB:`ADDR_BASE_LSB]
                      == board_address);
  assign cycle_sel = board_sel
                   & (host.in_cycle | host.out_cycle);
  assign port_sel  = host.addr[`ADDR_PORT_BIT];
  assign reg_sel   = host.addr[`ADDR_RSEL_BIT];

  // enable pulse follows either cpu strobe
  assign strobe_on = ~host.wr_strobe_n | host.din_strobe;

  // chip side controls
  assign chip.chip_select_low_n = ~cycle_sel;
  assign chip.chip_select_high  = cycle_sel
                                ? (port_sel ? 2'h2 : 2'h1)
                                : 2'h0;
  assign chip.register_select   = reg_sel;
  assign chip.read_not_write    = ~(cycle_sel & host.out_cycle);
  assign chip.enable            = cycle_sel & strobe_on;

  // write path drives the chip only in a selected output cycle
  assign chip_wdata    = host.dout;
  assign chip_wdata_oe = cycle_sel & host.out_cycle;

  // read path: registered copy of addressed port
  assign rd_access = cycle_sel & host.in_cycle & host.din_strobe;
  assign nxt_din   = rd_access ? (port_sel ? port1_rdata : port0_rdata)
                               : din_ff;
  assign cpu_data_in    = din_ff;
  assign cpu_data_in_oe = cycle_sel & host.in_cycle;

  // wait flip-flop: set on start of input cycle, cleared by acknowledge
  assign in_start = cycle_sel & host.in_cycle & ~in_seen_ff;
  always_comb begin
    nxt_wait = wait_ff;
    if (cpu_wait_ack) begin
      nxt_wait = serial_bus_decode_pkg::wait_idle;
    end else if (in_start) begin
      nxt_wait = serial_bus_decode_pkg::wait_hold;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_ff <= serial_bus_decode_pkg::wait_idle;
    end else if (power_on_clear) begin
      wait_ff <= serial_bus_decode_pkg::wait_idle;
    end else begin
      wait_ff <= nxt_wait;
    end
  end

  // remembers that this input cycle already took its wait
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      in_seen_ff <= 1'b0;
    end else begin
      in_seen_ff <= cycle_sel & host.in_cycle;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      din_ff <= `DIN_RESET;
    end else begin
      din_ff <= nxt_din;
    end
  end

  // ready line low only while wait is held
  assign bus_ready_line =
    (wait_ff == serial_bus_decode_pkg::wait_idle);

endmodule

// file: hw/serial_bus_decode_map.svh
`ifndef SERIAL_BUS_DECODE_MAP_SVH
`define SERIAL_BUS_DECODE_MAP_SVH

// register index within a board, taken from address bits one and zero
`define PORT0_CONTROL_STATUS_IDX 2'h0
`define PORT0_DATA_BUFFER_IDX    2'h1
`define PORT1_CONTROL_STATUS_IDX 2'h2
`define PORT1_DATA_BUFFER_IDX    2'h3

// field positions on the io address
`define ADDR_BASE_MSB 7
`define ADDR_BASE_LSB 2
`define ADDR_PORT_BIT 1
`define ADDR_RSEL_BIT 0

// reset values
`define WAIT_RESET    1'b0
`define DIN_RESET     8'h00

// nominal wait length and its cycle count at 200 MHz (5 ns period)
`define WAIT_TIME_NS  500
`define CLK_PERIOD_NS 5
`define WAIT_CYCLES   (`WAIT_TIME_NS / `CLK_PERIOD_NS)

`endif

// file: hw/serial_bus_decode_pkg.sv
package serial_bus_decode_pkg;

  // one io bus cycle as the host presents it
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] dout;
    logic       in_cycle;
    logic       out_cycle;
    logic       wr_strobe_n;
    logic       din_strobe;
  } host_cycle_s;

  // selects driven toward the two serial chips
  typedef struct packed {
    logic       chip_select_low_n;
    logic [1:0] chip_select_high;
    logic       register_select;
    logic       read_not_write;
    logic       enable;
  } chip_ctrl_s;

  typedef enum logic {
    wait_idle,
    wait_hold
  } wait_state_e;

endpackage
